// ===== src/prco_pkg.sv
package prco_pkg;
    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [11:0] PRCO_OFS_RST0 = 12'h004;
    localparam logic [11:0] PRCO_OFS_CLKCTRL = 12'h008;
    localparam int PRCO_NUM_RST = 11;
    // reset request bit positions, in line index order
    localparam int PRCO_BIT_DMA = 0;
    localparam int PRCO_BIT_WATCHDOG0_RESET = 1;
    localparam int PRCO_BIT_IO0 = 2;
    localparam int PRCO_BIT_IO1 = 3;
    localparam int PRCO_BIT_TIMER0_RESET = 5;
    localparam int PRCO_BIT_TMR1 = 6;
    localparam int PRCO_BIT_TMR2 = 7;
    localparam int PRCO_BIT_TIMER3_RESET = 8;
    localparam int PRCO_BIT_AS0 = 11;
    localparam int PRCO_BIT_SS0 = 13;
    localparam int PRCO_BIT_SS1 = 14;
    localparam int PRCO_BIT_TW0 = 16;
    // -------------------------------------------------------------
    // clock control fields
    // -------------------------------------------------------------
    localparam int PRCO_BIT_INRO_RDY = 29;
    localparam int PRCO_BIT_BAUD_RDY = 28;
    localparam int PRCO_BIT_PRIM_RDY = 27;
    localparam int PRCO_BIT_EXTH_RDY = 24;
    localparam int PRCO_BIT_BAUD_VS = 21;
    localparam int PRCO_BIT_BAUD_EN = 20;
    localparam int PRCO_BIT_PRIM_EN = 19;
    localparam int PRCO_BIT_EXTH_EN = 16;
    localparam int PRCO_LSB_PRIM_DIV = 14;
    localparam int PRCO_BIT_SW_RDY = 13;
    localparam int PRCO_LSB_SEL = 9;
    localparam logic [1:0] PRCO_RSV_HI = 2'h1;
    localparam logic [5:0] PRCO_RSV_LO = 6'h08;
    localparam logic [1:0] PRCO_DNM_RST = 2'h0;
    localparam logic [2:0] PRCO_SEL_RST = 3'h4;
    localparam logic [2:0] PRCO_SEL_EXTH = 3'h2;
    localparam logic [2:0] PRCO_SEL_INRO = 3'h3;
    localparam logic [2:0] PRCO_SEL_PRIM = 3'h4;
    localparam logic [2:0] PRCO_SEL_BAUD = 3'h5;
    localparam logic [2:0] PRCO_SEL_EXTP = 3'h7;
    localparam logic PRCO_BAUD_EN_RST = 1'b0;
    localparam logic PRCO_PRIM_EN_RST = 1'b1;
    localparam logic PRCO_EXTH_EN_RST = 1'b0;
    localparam logic [31:0] PRCO_SLVERR_DATA = 32'h0000_0000;
    // cycles a stale synced switch done is ignored after a select write
    localparam logic [1:0] PRCO_SW_BLANK = 2'h3;
endpackage : prco_pkg

// ===== src/prco_rst_if.sv
`timescale 1ns/1ps
interface prco_rst_if #(parameter int N = 11);
    logic [N-1:0] set_req;
    logic [N-1:0] done;
    logic [N-1:0] pending;
    logic [N-1:0] line;
    modport ctl (input set_req, input done, output pending, output line);
    modport usr (output set_req, output done, input pending, input line);
endinterface : prco_rst_if

// ===== src/prco_rst_chan.sv
`timescale 1ns/1ps
module prco_rst_chan #(
    parameter int N = 11
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    prco_rst_if.ctl rif
);
    logic [N-1:0] pend_q;
    logic [N-1:0] pend_d;
    // -------------------------------------------------------------
    // per line request latch
    // -------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            // set wins over a simultaneous done
            always_comb begin
                pend_d[g] = pend_q[g];
                if (rif.done[g]) begin
                    pend_d[g] = 1'b0; // see (RL2)
                end
                if (rif.set_req[g]) begin
                    pend_d[g] = 1'b1;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end
    assign rif.pending = pend_q;
    assign rif.line = pend_q; // see (RL12)

    a_hold_until_done: assert property (@(posedge clk_in) // see (RL2)
        disable iff (!rst_b_in)
        (pend_q != '0 && rif.done == '0 && rif.set_req == '0)
        |=> (pend_q == $past(pend_q)))
        else $error("reset request dropped without done");
endmodule : prco_rst_chan

// ===== src/prco_top.sv
// What this block does
// (RL1) bits 5..8 written one reset timers 0..3.
// (RL2) request bit stays set until peripheral reports reset done; two-wire bit 16 has no done input and clears itself two cycles after set.
// (RL3) bit 0 dma, bit 1 watchdog0, bits 2,3 io ports 0,1.
// (RL4) bit 11 async serial0, 13/14 sync serial, 16 two-wire, write one.
// (RL5) ready flags 29,28,27,24 report oscillator running and ready.
// (RL6) enables: baud bit 20 rst 0, primary 19 rst 1, ext 16 rst 0.
// (RL7) prescaler 15:14 divides primary oscillator by 1,2,4,8.
// (RL8) switch ready bit 13 low from select change until switchover done.
// (RL9) bit 21 picks baud oscillator supply: 0 regulated 1V, 1 core.
// (RL10) software keeps bits 18:17 at reset value.
// (RL11) select 11:9 resets to 4; write clears switch ready at once.
// (RL12) reset line held while request set, released with bit on done; two-wire bit 16 drives no line, others lag the bit by one cycle.
`timescale 1ns/1ps
module prco_top (
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [10:0] RST_DONE_IN,
    output logic [10:0] PERIPH_RST_OUT,
    input wire logic INRO_RDY_IN,
    input wire logic BAUD_RDY_IN,
    input wire logic PRIM_RDY_IN,
    input wire logic EXTH_RDY_IN,
    input wire logic SW_DONE_IN,
    output logic BAUD_EN_OUT,
    output logic PRIM_EN_OUT,
    output logic EXTH_EN_OUT,
    output logic BAUD_OSC_SUPPLY_SELECT_OUT,
    output logic [1:0] PRIM_DIV_OUT,
    output logic [2:0] SYSTEM_OSCILLATOR_SEL_OUT
);
    localparam int N = prco_pkg::PRCO_NUM_RST;
    localparam int POS [N] = '{prco_pkg::PRCO_BIT_DMA,
        prco_pkg::PRCO_BIT_WATCHDOG0_RESET, prco_pkg::PRCO_BIT_IO0,
        prco_pkg::PRCO_BIT_IO1, prco_pkg::PRCO_BIT_TIMER0_RESET,
        prco_pkg::PRCO_BIT_TMR1, prco_pkg::PRCO_BIT_TMR2,
        prco_pkg::PRCO_BIT_TIMER3_RESET, prco_pkg::PRCO_BIT_AS0,
        prco_pkg::PRCO_BIT_SS0, prco_pkg::PRCO_BIT_SS1};
    // two-wire is kept apart so the channel count stays 11 plus one
    // -------------------------------------------------------------
    // synchronisers for asynchronous status inputs
    // -------------------------------------------------------------
    localparam int NS = N + 5;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    logic [NS-1:0] s_raw;
    assign s_raw = {RST_DONE_IN, INRO_RDY_IN, BAUD_RDY_IN, PRIM_RDY_IN,
        EXTH_RDY_IN, SW_DONE_IN};
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s_raw;
            s2_q <= s1_q;
        end
    end
    logic [N-1:0] done_s;
    logic inro_s, baud_s, prim_s, exth_s, swd_s;
    assign done_s = s2_q[NS-1 -: N];
    assign inro_s = s2_q[4];
    assign baud_s = s2_q[3];
    assign prim_s = s2_q[2];
    assign exth_s = s2_q[1];
    assign swd_s = s2_q[0];
    // -------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------
    logic acc, wr, hit_rst, hit_clk, full_wr;
    assign acc = PSEL_IN && PENABLE_IN;
    assign wr = acc && PWRITE_IN;
    assign hit_rst = (PADDR_IN == prco_pkg::PRCO_OFS_RST0);
    assign hit_clk = (PADDR_IN == prco_pkg::PRCO_OFS_CLKCTRL);
    assign full_wr = wr && hit_clk;
    // per-lane write mask
    logic [31:0] wmask;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            wmask[i] = PSTRB_IN[i/8];
        end
    end
    logic [31:0] wbits;
    assign wbits = PWDATA_IN & wmask;
    // -------------------------------------------------------------
    // reset requests
    // -------------------------------------------------------------
    prco_rst_if #(.N(N + 1)) rif ();
    logic [N:0] set_req;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_set
            // see (RL1) see (RL3) see (RL4)
            assign set_req[g] = wr && hit_rst && wbits[POS[g]];
        end
    endgenerate
    // see (RL4)
    assign set_req[N] = wr && hit_rst && wbits[prco_pkg::PRCO_BIT_TW0];
    logic tw_done_q;
    assign rif.set_req = set_req;
    assign rif.done = {tw_done_q, done_s};
    prco_rst_chan #(.N(N + 1)) u_chan (
        .clk_in(SYS_CLK_IN),
        .rst_b_in(RST_B_IN),
        .rif(rif)
    );
    // two-wire has no done pin: it completes one cycle after set
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tw_done_q <= 1'b0;
        end else begin
            tw_done_q <= rif.pending[N];
        end
    end
    // -------------------------------------------------------------
    // switch ready blanking
    // -------------------------------------------------------------
    // synced done lags a select write by the sync depth: ignore it
    // briefly, so the switch unit must drop done within one cycle
    logic [1:0] blank_q, blank_d;
    always_comb begin
        blank_d = blank_q;
        if (full_wr && PSTRB_IN[1]) begin
            blank_d = prco_pkg::PRCO_SW_BLANK;
        end else if (blank_q != 2'h0) begin
            blank_d = blank_q - 2'h1;
        end
    end
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            blank_q <= 2'h0;
        end else begin
            blank_q <= blank_d;
        end
    end
    // -------------------------------------------------------------
    // clock control state
    // -------------------------------------------------------------
    logic baud_en_q, prim_en_q, exth_en_q, vs_q, swrdy_q;
    logic baud_en_d, prim_en_d, exth_en_d, vs_d, swrdy_d;
    logic [1:0] div_q, div_d, dnm_q, dnm_d;
    logic [2:0] sel_q, sel_d;
    always_comb begin
        baud_en_d = baud_en_q;
        prim_en_d = prim_en_q;
        exth_en_d = exth_en_q;
        vs_d = vs_q;
        div_d = div_q;
        dnm_d = dnm_q;
        sel_d = sel_q;
        swrdy_d = swrdy_q;
        if (swd_s && blank_q == 2'h0) begin
            swrdy_d = 1'b1; // see (RL8)
        end
        if (full_wr && PSTRB_IN[2]) begin
            baud_en_d = PWDATA_IN[prco_pkg::PRCO_BIT_BAUD_EN]; // see (RL6)
            prim_en_d = PWDATA_IN[prco_pkg::PRCO_BIT_PRIM_EN];
            exth_en_d = PWDATA_IN[prco_pkg::PRCO_BIT_EXTH_EN];
            vs_d = PWDATA_IN[prco_pkg::PRCO_BIT_BAUD_VS]; // see (RL9)
            dnm_d = PWDATA_IN[18:17]; // see (RL10)
        end
        if (full_wr && PSTRB_IN[1]) begin
            div_d = PWDATA_IN[prco_pkg::PRCO_LSB_PRIM_DIV +: 2]; // see (RL7)
            sel_d = PWDATA_IN[prco_pkg::PRCO_LSB_SEL +: 3];
            swrdy_d = 1'b0; // see (RL11)
        end
    end
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            baud_en_q <= prco_pkg::PRCO_BAUD_EN_RST;
            prim_en_q <= prco_pkg::PRCO_PRIM_EN_RST;
            exth_en_q <= prco_pkg::PRCO_EXTH_EN_RST;
            vs_q <= 1'b0;
            div_q <= 2'h0;
            dnm_q <= prco_pkg::PRCO_DNM_RST;
            sel_q <= prco_pkg::PRCO_SEL_RST; // see (RL11)
            swrdy_q <= 1'b0;
        end else begin
            baud_en_q <= baud_en_d;
            prim_en_q <= prim_en_d;
            exth_en_q <= exth_en_d;
            vs_q <= vs_d;
            div_q <= div_d;
            dnm_q <= dnm_d;
            sel_q <= sel_d;
            swrdy_q <= swrdy_d;
        end
    end
    // -------------------------------------------------------------
    // read mux, one wait-free access cycle
    // -------------------------------------------------------------
    logic [31:0] clk_rd, rst_rd, rd_d, rd_q;
    logic slv_d, slv_q, rdy_q;
    always_comb begin
        rst_rd = '0;
        for (int i = 0; i < N; i++) begin
            rst_rd[POS[i]] = rif.pending[i];
        end
        rst_rd[prco_pkg::PRCO_BIT_TW0] = rif.pending[N];
    end
    always_comb begin
        clk_rd = '0;
        clk_rd[31:30] = prco_pkg::PRCO_RSV_HI;
        // baud, primary and ext flags gated by enable: a stale ready never shows when off
        clk_rd[prco_pkg::PRCO_BIT_INRO_RDY] = inro_s; // see (RL5)
        clk_rd[prco_pkg::PRCO_BIT_BAUD_RDY] = baud_s && baud_en_q;
        clk_rd[prco_pkg::PRCO_BIT_PRIM_RDY] = prim_s && prim_en_q;
        clk_rd[prco_pkg::PRCO_BIT_EXTH_RDY] = exth_s && exth_en_q;
        clk_rd[prco_pkg::PRCO_BIT_BAUD_VS] = vs_q;
        clk_rd[prco_pkg::PRCO_BIT_BAUD_EN] = baud_en_q;
        clk_rd[prco_pkg::PRCO_BIT_PRIM_EN] = prim_en_q;
        clk_rd[18:17] = dnm_q;
        clk_rd[prco_pkg::PRCO_BIT_EXTH_EN] = exth_en_q;
        clk_rd[prco_pkg::PRCO_LSB_PRIM_DIV +: 2] = div_q;
        clk_rd[prco_pkg::PRCO_BIT_SW_RDY] = swrdy_q;
        clk_rd[prco_pkg::PRCO_LSB_SEL +: 3] = sel_q;
        clk_rd[5:0] = prco_pkg::PRCO_RSV_LO;
    end
    always_comb begin
        rd_d = rd_q;
        slv_d = 1'b0;
        if (PSEL_IN && !PENABLE_IN) begin
            slv_d = !(hit_rst || hit_clk);
            if (!PWRITE_IN && hit_rst) begin
                rd_d = rst_rd;
            end else if (!PWRITE_IN && hit_clk) begin
                rd_d = clk_rd;
            end else begin
                rd_d = prco_pkg::PRCO_SLVERR_DATA;
            end
        end
    end
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rd_q <= '0;
            slv_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            slv_q <= slv_d;
            rdy_q <= PSEL_IN && !PENABLE_IN;
        end
    end
    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    logic [10:0] prst_q;
    always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            prst_q <= '0;
        end else begin
            prst_q <= rif.line[N-1:0]; // see (RL12)
        end
    end
    assign PERIPH_RST_OUT = prst_q;
    assign PRDATA_OUT = rd_q;
    assign PREADY_OUT = rdy_q;
    assign PSLVERR_OUT = slv_q;
    assign BAUD_EN_OUT = baud_en_q;
    assign PRIM_EN_OUT = prim_en_q;
    assign EXTH_EN_OUT = exth_en_q;
    assign BAUD_OSC_SUPPLY_SELECT_OUT = vs_q;
    assign PRIM_DIV_OUT = div_q;
    assign SYSTEM_OSCILLATOR_SEL_OUT = sel_q;

    a_sel_clears_rdy: assert property (@(posedge SYS_CLK_IN) // see (RL11)
        disable iff (!RST_B_IN)
        (full_wr && PSTRB_IN[1]) |=> !swrdy_q)
        else $error("switch ready not cleared by select write");
    a_rdy_on_done: assert property (@(posedge SYS_CLK_IN) // see (RL8)
        disable iff (!RST_B_IN)
        (swd_s && blank_q == 2'h0 && !(full_wr && PSTRB_IN[1]))
        |=> swrdy_q)
        else $error("switch ready not set after switchover");
    a_timer_req: assert property (@(posedge SYS_CLK_IN) // see (RL1)
        disable iff (!RST_B_IN)
        (wr && hit_rst && wbits[prco_pkg::PRCO_BIT_TIMER0_RESET])
        |=> ##1 PERIPH_RST_OUT[4])
        else $error("timer0 reset line not raised");
    a_dma_req: assert property (@(posedge SYS_CLK_IN) // see (RL3)
        disable iff (!RST_B_IN)
        (wr && hit_rst && wbits[prco_pkg::PRCO_BIT_DMA])
        |=> rst_rd[prco_pkg::PRCO_BIT_DMA])
        else $error("dma request bit not set");
    a_exth_flag_off: assert property (@(posedge SYS_CLK_IN) // see (RL5)
        disable iff (!RST_B_IN)
        (PSEL_IN && !PENABLE_IN && !PWRITE_IN && hit_clk && !exth_en_q)
        |=> !PRDATA_OUT[prco_pkg::PRCO_BIT_EXTH_RDY])
        else $error("ready shown for disabled oscillator");
    a_prim_en_out: assert property (@(posedge SYS_CLK_IN) // see (RL6)
        disable iff (!RST_B_IN)
        (full_wr && PSTRB_IN[2])
        |=> PRIM_EN_OUT == $past(PWDATA_IN[19]))
        else $error("primary enable not taken");
    a_div_out: assert property (@(posedge SYS_CLK_IN) // see (RL7)
        disable iff (!RST_B_IN)
        (full_wr && PSTRB_IN[1])
        |=> PRIM_DIV_OUT == $past(PWDATA_IN[15:14]))
        else $error("prescaler not taken");
    a_supply_sel: assert property (@(posedge SYS_CLK_IN) // see (RL9)
        disable iff (!RST_B_IN)
        (full_wr && PSTRB_IN[2])
        |=> BAUD_OSC_SUPPLY_SELECT_OUT == $past(PWDATA_IN[21]))
        else $error("supply select mismatch");
    a_serial_req: assert property (@(posedge SYS_CLK_IN) // see (RL4)
        disable iff (!RST_B_IN)
        (wr && hit_rst && wbits[prco_pkg::PRCO_BIT_SS1])
        |=> ##1 PERIPH_RST_OUT[10])
        else $error("sync serial1 reset not raised");
endmodule : prco_top

// ===== dv/prco_periph_model.sv
`timescale 1ns/1ps
module prco_periph_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic slow_in,
    input wire logic hold_in,
    input wire logic [10:0] line_in,
    input wire logic [3:0] osc_en_in,
    input wire logic [2:0] sel_in,
    output logic [10:0] done_out,
    output logic [3:0] rdy_out,
    output logic sw_done_out
);
    // -------------------------------------------------------------
    // peripherals, oscillators and clock switch
    // -------------------------------------------------------------
    logic [3:0] lat;
    logic [3:0] rcnt [11];
    logic [3:0] ocnt [4];
    logic [3:0] scnt;
    logic [2:0] sel_q;
    // slow mode stretches every acknowledge to catch early reads
    assign lat = slow_in ? 4'h6 : 4'h1;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_out <= '0;
            rdy_out <= '0;
            sw_done_out <= 1'b0;
            scnt <= '0;
            sel_q <= 3'h4;
            rcnt <= '{default: 4'h0};
            ocnt <= '{default: 4'h0};
        end else begin
            for (int i = 0; i < 11; i++) begin
                if (!line_in[i]) begin
                    rcnt[i] <= '0;
                    done_out[i] <= 1'b0;
                end else if (rcnt[i] >= lat) begin
                    done_out[i] <= 1'b1;
                end else begin
                    rcnt[i] <= rcnt[i] + 4'h1;
                end
            end
            for (int j = 0; j < 4; j++) begin
                if (!osc_en_in[j]) begin
                    ocnt[j] <= '0;
                    rdy_out[j] <= 1'b0;
                end else if (ocnt[j] >= lat) begin
                    rdy_out[j] <= 1'b1;
                end else begin
                    ocnt[j] <= ocnt[j] + 4'h1;
                end
            end
            sel_q <= sel_in;
            if (hold_in || sel_in != sel_q) begin
                scnt <= '0;
                sw_done_out <= 1'b0;
            end else if (scnt >= lat) begin
                sw_done_out <= 1'b1;
            end else begin
                scnt <= scnt + 4'h1;
            end
        end
    end
endmodule : prco_periph_model

// ===== dv/prco_top_tb.sv
`timescale 1ns/1ps
module prco_top_tb;
    logic clk, rst_b, psel, penable, pwrite, slow, hold, err, sw_done;
    logic baud_en, prim_en, exth_en, vs;
    logic [1:0] div;
    logic [2:0] sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, sh, old, d;
    logic [3:0] pstrb, rdy, s;
    logic [10:0] done, prst;
    int bad_count, check_count, n, seed;
    int bits [12] = '{0, 1, 2, 3, 5, 6, 7, 8, 11, 13, 14, 16};
    logic [2:0] codes [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    logic [31:0] rd_bus;
    logic rdy_bus, err_bus;

    prco_top u_prco_top (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(rd_bus), .PREADY_OUT(rdy_bus), .PSLVERR_OUT(err_bus),
        .RST_DONE_IN(done), .PERIPH_RST_OUT(prst), .INRO_RDY_IN(rdy[3]),
        .BAUD_RDY_IN(rdy[2]), .PRIM_RDY_IN(rdy[1]), .EXTH_RDY_IN(rdy[0]),
        .SW_DONE_IN(sw_done), .BAUD_EN_OUT(baud_en), .PRIM_EN_OUT(prim_en),
        .EXTH_EN_OUT(exth_en), .BAUD_OSC_SUPPLY_SELECT_OUT(vs),
        .PRIM_DIV_OUT(div), .SYSTEM_OSCILLATOR_SEL_OUT(sel));
    prco_periph_model u_prco_periph_model (.clk_in(clk), .rst_b_in(rst_b),
        .slow_in(slow), .hold_in(hold), .line_in(prst),
        .osc_en_in({1'b1, baud_en, prim_en, exth_en}), .sel_in(sel),
        .done_out(done), .rdy_out(rdy), .sw_done_out(sw_done));

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] dv, input logic [3:0] st);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dv;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rdy_bus !== 1'b1 && k < 16);
        rd = rd_bus;
        err = err_bus;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) begin
            bad_count++;
            $display("[ERR] %0t no ready", $time);
        end
    endtask : apb

    function automatic logic [31:0] exp_clk(input logic [31:0] v);
        logic [31:0] e;
        e = v;
        e[29] = 1'b1;
        e[28] = v[20];
        e[27] = v[19];
        e[24] = v[16];
        return e & ~32'h0000_2000;
    endfunction : exp_clk

    task automatic clk_wr(input logic [31:0] dv, input logic [3:0] st);
        apb(1'b1, 12'h008, dv, st);
        if (st[2]) sh = (sh & ~32'h003F_0000) | (dv & 32'h003F_0000);
        if (st[1]) sh = (sh & ~32'h0000_CE00) | (dv & 32'h0000_CE00);
    endtask : clk_wr

    task automatic rd_clk();
        apb(1'b0, 12'h008, '0, '0);
        chk(rd & ~32'h0000_2000, exp_clk(sh), "clkctrl");
        chk(32'(rd[13]), 32'h1, "switch ready");
        chk({23'h0, vs, baud_en, prim_en, exth_en, div, sel}, {23'h0,
            sh[21], sh[20], sh[19], sh[16], sh[15:14], sh[11:9]},
            "osc ports");
    endtask : rd_clk

    task automatic drain();
        n = 0;
        do begin
            apb(1'b0, 12'h004, '0, '0);
            n++;
        end while (rd !== '0 && n < 20);
        chk(rd, '0, "cleared");
        chk(32'(prst), '0, "released");
    endtask : drain

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // -------------------------------------------------------------
    // clock, watchdog and tests
    // -------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #(4 * 40000);
        bad_count++;
        $display("[ERR] %0t watchdog", $time);
        final_report();
    end

    initial begin
        {psel, penable, pwrite, hold, rst_b} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        slow = 1'b1;
        sh = 32'h4008_0808;
        seed = $urandom(24);
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (16) @(posedge clk);
        apb(1'b0, 12'h004, '0, '0);
        chk(rd, '0, "rst0 reset");
        rd_clk();
        apb(1'b1, 12'h00C, '1, 4'hF);
        chk(32'(err), 32'h1, "unmapped write");
        apb(1'b0, 12'h00C, '0, '0);
        chk(32'(err), 32'h1, "unmapped read");
        chk(rd, '0, "unmapped data");
        foreach (bits[k]) begin
            slow <= 1'($urandom_range(1));
            apb(1'b1, 12'h004, 32'h1 << bits[k], 4'hF);
            apb(1'b0, 12'h004, '0, '0);
            chk(rd, 32'h1 << bits[k], "pending");
            chk(32'(prst), k < 11 ? 32'h1 << k : 0, "line");
            drain();
        end
        slow <= 1'b1;
        apb(1'b1, 12'h004, '1, 4'hF);
        apb(1'b0, 12'h004, '0, '0);
        chk(rd, 32'h0001_69EF, "all pending");
        chk(32'(prst), 32'h7FF, "all lines");
        drain();
        repeat (24) begin
            d = $urandom;
            d[18:17] = 2'h0;
            d[11:9] = codes[$urandom_range(4)];
            s = 4'($urandom);
            old = sh;
            clk_wr(d, s);
            apb(1'b0, 12'h008, '0, '0);
            if (sh[16] && !old[16]) begin
                chk(32'(rd[24]), '0, "early ext");
            end
            if (sh[20] && !old[20]) begin
                chk(32'(rd[28]), '0, "early baud");
            end
            repeat (16) @(posedge clk);
            rd_clk();
        end
        hold <= 1'b1;
        repeat (8) @(posedge clk);
        d = sh;
        d[11:9] = (sh[11:9] == 3'h4) ? 3'h2 : 3'h4;
        clk_wr(d, 4'h2);
        repeat (16) @(posedge clk);
        apb(1'b0, 12'h008, '0, '0);
        chk(32'(rd[13]), '0, "switch pending");
        hold <= 1'b0;
        repeat (16) @(posedge clk);
        rd_clk();
        final_report();
    end
endmodule : prco_top_tb
